// >>> bench/asr_host_model.sv
// Host terminal model: sends command lines, collects reply characters.
// Assumes one clock shared with the command block.
`timescale 1ns/1ps
module asr_host_model (
   // Clock
   input  wire logic               core_clk_i,
   // Characters to the block
   output asr_pkg::asr_byte_t      rx_data_o,
   output logic                    rx_valid_o,
   input  wire logic               rx_ready_i,
   // Characters from the block
   input  wire asr_pkg::asr_byte_t tx_data_i,
   input  wire logic               tx_valid_i,
   output logic                    tx_ready_o
);
   import asr_pkg::*;
   string heard = "";
   bit    slow  = 1'b0;
   initial begin
      rx_data_o  = 8'h00;
      rx_valid_o = 1'b0;
      tx_ready_o = 1'b1;
   end
   // ****************************************************************
   // A slow host accepts a reply character only every other cycle.
   // ****************************************************************
   always @(posedge core_clk_i) begin
      if (tx_valid_i === 1'b1 && tx_ready_o)
         heard = $sformatf("%s%c", heard, tx_data_i);
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
   end
   task automatic send_line(input string s, output bit ok);
      int i;
      int n;
      ok = 1'b1;
      for (i = 0; i < s.len(); i++) begin
         rx_data_o  <= s[i];
         rx_valid_o <= 1'b1;
         n = 0;
         do begin
            @(posedge core_clk_i);
            n++;
         end while (rx_ready_i !== 1'b1 && n < 2000);
         if (n >= 2000) ok = 1'b0;
      end
      // The released line shows the inverse of the last character.
      rx_valid_o <= 1'b0;
      rx_data_o  <= ~s[s.len()-1];
   endtask
endmodule // asr_host_model

// >>> bench/asr_top_assertions.sv
// Port checker for the AT command block.
// Assumes it is bound into asr_top and sees only its ports.
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_top_assertions #(
   parameter int NUM_SREG = 32
) (
   input  wire logic               core_clk_i,
   input  wire logic               reset_i,
   input  wire logic               hsel_i,
   input  wire logic [1:0]         htrans_i,
   input  wire logic               hwrite_i,
   input  wire logic               hready_i,
   input  wire logic               hreadyout_o,
   input  wire logic               hresp_o,
   input  wire logic               rx_ready_o,
   input  wire asr_pkg::asr_byte_t tx_data_o,
   input  wire logic               tx_valid_o,
   input  wire logic               tx_ready_i
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_rd_taken;
      hsel_i && htrans_i[1] && hready_i && !hwrite_i;
   endsequence
   sequence s_wr_taken;
      hsel_i && htrans_i[1] && hready_i && hwrite_i;
   endsequence
   sequence s_one_wait;
      !hreadyout_o ##1 hreadyout_o;
   endsequence
   property p_read_wait;
      s_rd_taken |=> s_one_wait;
   endproperty
   a_read_wait: assert property (p_read_wait)
      else $error("read data phase is not exactly one wait");
   property p_write_nowait;
      s_wr_taken |=> hreadyout_o;
   endproperty
   a_write_nowait: assert property (p_write_nowait)
      else $error("write data phase stalled");
   property p_wait_cause;
      !hreadyout_o |-> $past(hsel_i && htrans_i[1] && hready_i && !hwrite_i);
   endproperty
   a_wait_cause: assert property (p_wait_cause)
      else $error("wait state without a read");
   property p_okay;
      hresp_o == 1'b0;
   endproperty
   a_okay: assert property (p_okay)
      else $error("error response seen");
   property p_tx_hold;
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
   endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("reply character dropped or changed");
   property p_rx_blocked;
      tx_valid_o |-> !rx_ready_o;
   endproperty
   a_rx_blocked: assert property (p_rx_blocked)
      else $error("input taken while a reply is offered");
   property p_reply_head;
      $rose(tx_valid_o) |-> tx_data_o == `ASR_CH_CR ||
         tx_data_o inside {[`ASR_CH_0:`ASR_CH_9]};
   endproperty
   a_reply_head: assert property (p_reply_head)
      else $error("reply starts with an unexpected character");
   property p_release;
      $fell(reset_i) |-> rx_ready_o && !tx_valid_o && hreadyout_o;
   endproperty
   a_release: assert property (p_release)
      else $error("block not idle after reset");
endmodule // asr_top_assertions
bind asr_top asr_top_assertions #(.NUM_SREG(NUM_SREG)) u_asr_chk (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
   .tx_ready_i(tx_ready_i));

// >>> bench/asr_top_tb.sv
// Self-checking bench: bus register tasks and AT command lines.
// Assumes the host model drives the character link.
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_top_tb;
   import asr_pkg::*;
   logic        core_clk_i, reset_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
   logic [1:0]  htrans_i;
   logic        rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
   asr_byte_t   rx_data_i, tx_data_o;
   int          fail_count   = 0;
   int          total_checks = 0;
   asr_top dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hready_i(hreadyout_o),
      .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
      .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
   asr_host_model host (.core_clk_i(core_clk_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
      .rx_ready_i(rx_ready_o), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
      .tx_ready_o(tx_ready_i));
   // ****************************************************************
   // Checking and bus tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         fail_count++;
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (hreadyout_o !== 1'b1 && n < 100);
      if (n >= 100) begin
         fail_count++;
         tally_and_finish;
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk_i);
      hsel_i   <= 1'b1;
      haddr_i  <= {24'h000000, a};
      hwrite_i <= wr;
      htrans_i <= 2'b10;
      wait_ready;
      htrans_i <= 2'b00;
      hwdata_i <= wd;
      wait_ready;
      rd = hrdata_o;
   endtask
   // Sends one line, waits for the link to fall quiet, compares the reply.
   task automatic line(input string cmd, input string exp);
      int q;
      int n;
      bit ok;
      host.heard = "";
      host.send_line(cmd, ok);
      q = 0;
      for (n = 0; n < 3000 && q < 20; n++) begin
         @(posedge core_clk_i);
         q = (tx_valid_o === 1'b0) ? q + 1 : 0;
      end
      if (!ok || q < 20) begin
         fail_count++;
         tally_and_finish;
      end
      check(host.heard.len(), exp.len());
      for (n = 0; n < exp.len(); n++)
         check(host.heard[n], exp[n]);
   endtask
   // ****************************************************************
   // Clock, reset and scenarios
   // ****************************************************************
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   initial begin
      reset_i  = 1'b1;
      hsel_i   = 1'b0;
      haddr_i  = 32'h0;
      hwrite_i = 1'b0;
      htrans_i = 2'b00;
      hwdata_i = 32'h0;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      bus(1'b0, `ASR_OFS_STATUS, 32'h0);
      check(rd, 32'h00000b00);
      bus(1'b0, `ASR_OFS_CTRL, 32'h0);
      check(rd, 32'h00000001);
      bus(1'b0, 8'h10, 32'h0);
      check(rd, 32'h00000000);
      line("ATS14?\r", "\r\n8\r\n\r\nOK\r\n");
      line("ATQ1\r", "");
      line("ATS14?\r", "\r\n12\r\n");
      bus(1'b0, `ASR_OFS_STATUS, 32'h0);
      check(rd, 32'h00000a0e);
      host.slow = 1'b1;
      line("ATQ0V0\r", "0\r");
      line("AT?\r", "0\r\n0\r");
      line("ATV1\r", "\r\nOK\r\n");
      host.slow = 1'b0;
      line("ATS6\r", "\r\nOK\r\n");
      bus(1'b0, `ASR_OFS_STATUS, 32'h0);
      check(rd, 32'h00000b06);
      bus(1'b1, `ASR_OFS_PEEK_IDX, 32'd6);
      bus(1'b0, `ASR_OFS_PEEK_DATA, 32'h0);
      check(rd, 32'h00000000);
      line("AT=300?\r", "\r\n44\r\n\r\nOK\r\n");
      bus(1'b0, `ASR_OFS_PEEK_DATA, 32'h0);
      check(rd, 32'h00002c2c);
      line("ATS3=9S3?\r", "\r\n9\r\n\r\nOK\r\n");
      line("ATS24=7\r", "\r\nOK\r\n");
      bus(1'b1, `ASR_OFS_PEEK_IDX, 32'd24);
      bus(1'b0, `ASR_OFS_PEEK_DATA, 32'h0);
      check(rd, 32'h07070707);
      line("ATS=5?\r", "\r\n5\r\n\r\nOK\r\n");
      bus(1'b1, `ASR_OFS_CTRL, 32'h00000003);
      bus(1'b0, `ASR_OFS_PEEK_DATA, 32'h0);
      check(rd, 32'h05050000);
      bus(1'b0, `ASR_OFS_STATUS, 32'h0);
      check({28'h0, rd[11:8]}, 32'h0000000b);
      bus(1'b1, `ASR_OFS_CTRL, 32'h0);
      line("ATQ1\r", "");
      bus(1'b1, `ASR_OFS_CTRL, 32'h00000001);
      line("AT\r", "\r\nOK\r\n");
      // Unknown letter, refused Q argument, bare V, too large a register number.
      line("ATX2Q5VS133?V1\r", "0\r\n\r\nOK\r\n");
      bus(1'b0, `ASR_OFS_STATUS, 32'h0);
      check(rd, 32'h00000b18);
      tally_and_finish;
   end
endmodule // asr_top_tb

// >>> logic/asr_defs.svh
// Constants of the AT result-option and S-register command block.
// Assumes inclusion by bare name from files under logic/.
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// ****************************************************************
// S-register file
// ****************************************************************
`define ASR_NUM_SREG      32
`define ASR_IDX_OPT       14
`define ASR_IDX_PROF      24
`define ASR_QUIET_BIT     2
`define ASR_VERBOSE_BIT   3
`define ASR_OPT_RESET     8'h08
`define ASR_SREG_RESET    8'h00
`define ASR_NUM_MAX       7'h63
`define ASR_VAL_MAX       10'h3e7

// ****************************************************************
// Bus register byte offsets and reset values
// ****************************************************************
`define ASR_OFS_CTRL      8'h00
`define ASR_OFS_STATUS    8'h04
`define ASR_OFS_PEEK_IDX  8'h08
`define ASR_OFS_PEEK_DATA 8'h0c
`define ASR_CTRL_EN_BIT   0
`define ASR_CTRL_FACT_BIT 1
`define ASR_CTRL_RESET    1'b1

// ****************************************************************
// Character codes
// ****************************************************************
`define ASR_CH_CR         8'h0d
`define ASR_CH_LF         8'h0a
`define ASR_CH_SP         8'h20
`define ASR_CH_0          8'h30
`define ASR_CH_9          8'h39
`define ASR_CH_A          8'h41
`define ASR_CH_T          8'h54
`define ASR_CH_Q          8'h51
`define ASR_CH_V          8'h56
`define ASR_CH_S          8'h53
`define ASR_CH_O          8'h4f
`define ASR_CH_K          8'h4b
`define ASR_CH_EQ         8'h3d
`define ASR_CH_QM         8'h3f
`define ASR_CASE_MASK     8'hdf

`endif

// >>> logic/asr_pkg.sv
// Types shared by the AT command block.
// Assumes nothing of its surroundings.
package asr_pkg;

   typedef enum logic [2:0] {
      ST_IDLE, ST_GOT_A, ST_CMD, ST_ARG, ST_SNUM, ST_SVAL, ST_EMIT
   } asr_state_t;

   typedef enum logic [1:0] {
      CK_QUIET, CK_VERBOSE, CK_OTHER
   } asr_kind_t;

   typedef logic [7:0] asr_byte_t;

endpackage

// >>> logic/asr_sreg_file.sv
// S-register store: active set, two stored profiles, clamped view.
// Assumes one clock and a parser that drives the ctl modport.
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_sreg_file #(
   parameter int                      NUM_SREG  = `ASR_NUM_SREG,
   parameter int                      IDX_W     = 5,
   parameter logic [NUM_SREG*8-1:0]   LO_LIMITS = '0,
   parameter logic [NUM_SREG*8-1:0]   HI_LIMITS = '1
) (
   // Clock and reset
   input  wire logic   core_clk_i,
   input  wire logic   reset_i,
   // Parser side
   asr_sreg_if.store   sif
);
   import asr_pkg::*;

   asr_byte_t active [NUM_SREG];
   asr_byte_t prof0  [NUM_SREG];
   asr_byte_t prof1  [NUM_SREG];

   function automatic asr_byte_t reset_val(input int i);
      return (i == `ASR_IDX_OPT) ? `ASR_OPT_RESET : `ASR_SREG_RESET;
   endfunction

   wire             wr_ok       = int'(sif.wr_idx) < NUM_SREG;
   wire             rd_ok       = int'(sif.rd_idx) < NUM_SREG;
   wire             pk_ok       = int'(sif.pk_idx) < NUM_SREG;
   wire asr_byte_t  wr_old      = wr_ok ? active[sif.wr_idx] : 8'h00;
   wire asr_byte_t  merged      = (wr_old & ~sif.wr_mask) | (sif.wr_data & sif.wr_mask);
   wire             to_profiles = sif.wr_idx == IDX_W'(`ASR_IDX_PROF);
   wire asr_byte_t  lo          = LO_LIMITS[sif.pk_idx*8 +: 8];
   wire asr_byte_t  hi          = HI_LIMITS[sif.pk_idx*8 +: 8];

   // Values are kept as written; only the operating view is clamped.
   assign sif.rd_raw   = rd_ok ? active[sif.rd_idx] : 8'h00;
   assign sif.pk_raw   = pk_ok ? active[sif.pk_idx] : 8'h00;
   assign sif.pk_eff   = (sif.pk_raw < lo) ? lo : (sif.pk_raw > hi) ? hi : sif.pk_raw;
   assign sif.pk_prof0 = pk_ok ? prof0[sif.pk_idx] : 8'h00;
   assign sif.pk_prof1 = pk_ok ? prof1[sif.pk_idx] : 8'h00;
   assign sif.opt      = active[`ASR_IDX_OPT];

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < NUM_SREG; i++) begin
            active[i] <= reset_val(i);
            prof0[i]  <= reset_val(i);
            prof1[i]  <= reset_val(i);
         end
      end else if (sif.fact_load) begin
         for (int i = 0; i < NUM_SREG; i++) begin
            active[i] <= reset_val(i);
         end
      end else if (sif.wr_en && wr_ok) begin
         active[sif.wr_idx] <= merged;
         if (to_profiles) begin
            prof0[sif.wr_idx] <= merged;
            prof1[sif.wr_idx] <= merged;
         end
      end
   end

endmodule // asr_sreg_file

// >>> logic/asr_sreg_if.sv
// Carrier between the command parser and the S-register store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface asr_sreg_if #(
   parameter int IDX_W = 5
);
   logic             wr_en;
   logic [IDX_W-1:0] wr_idx;
   logic [7:0]       wr_data;
   logic [7:0]       wr_mask;
   logic             fact_load;
   logic [IDX_W-1:0] rd_idx;
   logic [7:0]       rd_raw;
   logic [IDX_W-1:0] pk_idx;
   logic [7:0]       pk_raw;
   logic [7:0]       pk_eff;
   logic [7:0]       pk_prof0;
   logic [7:0]       pk_prof1;
   logic [7:0]       opt;

   modport ctl (
      output wr_en, wr_idx, wr_data, wr_mask, fact_load, rd_idx, pk_idx,
      input  rd_raw, pk_raw, pk_eff, pk_prof0, pk_prof1, opt
   );
   modport store (
      input  wr_en, wr_idx, wr_data, wr_mask, fact_load, rd_idx, pk_idx,
      output rd_raw, pk_raw, pk_eff, pk_prof0, pk_prof1, opt
   );
endinterface // asr_sreg_if

// >>> logic/asr_top.sv
// AT command interpreter for result display, result format and S-registers.
// Assumes a byte stream with valid/ready in each direction and an AHB-Lite
// master alone on the bus, all on core_clk_i.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "asr_defs.svh"

module asr_top #(
   parameter int NUM_SREG = `ASR_NUM_SREG
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hwdata_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Command characters from the host
   input  wire asr_pkg::asr_byte_t rx_data_i,
   input  wire logic        rx_valid_i,
   output logic             rx_ready_o,
   // Reply characters to the host
   output asr_pkg::asr_byte_t tx_data_o,
   output logic             tx_valid_o,
   input  wire logic        tx_ready_i
);
   import asr_pkg::*;

   localparam int IDX_W = (NUM_SREG > 1) ? $clog2(NUM_SREG) : 1;

   // ****************************************************************
   // Register store
   // ****************************************************************
   asr_sreg_if #(.IDX_W(IDX_W)) sif ();

   asr_sreg_file #(
      .NUM_SREG (NUM_SREG),
      .IDX_W    (IDX_W)
   ) u_store (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .sif        (sif)
   );

   // ****************************************************************
   // Parser state
   // ****************************************************************
   asr_state_t        state, next_state;
   asr_kind_t         kind, next_kind;
   logic [IDX_W-1:0]  pointer, next_pointer;
   logic [3:0]        arg, next_arg;
   logic [6:0]        num, next_num;
   logic              num_seen, next_num_seen;
   logic [9:0]        val, next_val;
   logic [63:0]       emit_buf, next_emit_buf;
   logic [3:0]        emit_len, next_emit_len;
   logic [3:0]        emit_pos, next_emit_pos;
   logic              emit_last, next_emit_last;
   asr_byte_t         next_tx_data;
   logic              next_tx_valid;
   logic              enable;
   logic [IDX_W-1:0]  pk_idx;

   // ****************************************************************
   // Character decode
   // ****************************************************************
   wire asr_byte_t ch       = rx_data_i & `ASR_CASE_MASK;
   wire            is_digit = (rx_data_i >= `ASR_CH_0) && (rx_data_i <= `ASR_CH_9);
   wire [3:0]      digit    = 4'(rx_data_i - `ASR_CH_0);
   wire            is_cr    = rx_data_i == `ASR_CH_CR;
   wire            in_num   = (state == ST_ARG) || (state == ST_SNUM) || (state == ST_SVAL);
   // A non-digit ends a number field; it is held and seen again in ST_CMD.
   wire            hold     = in_num && rx_valid_i && !is_digit;
   assign rx_ready_o = !enable || ((state != ST_EMIT) && !hold);
   wire            rx_fire  = enable && rx_valid_i && rx_ready_o;
   wire            quiet    = sif.opt[`ASR_QUIET_BIT];
   wire            verbose  = sif.opt[`ASR_VERBOSE_BIT];
   wire            num_ok   = num_seen && (int'(num) < NUM_SREG);

   // ****************************************************************
   // Reply text
   // ****************************************************************
   wire asr_byte_t qv     = sif.rd_raw;
   wire asr_byte_t d_h    = `ASR_CH_0 + 8'(qv / 8'd100);
   wire asr_byte_t d_t    = `ASR_CH_0 + 8'((qv / 8'd10) % 8'd10);
   wire asr_byte_t d_u    = `ASR_CH_0 + 8'(qv % 8'd10);
   wire [1:0]      dlen   = (qv >= 8'd100) ? 2'd3 : (qv >= 8'd10) ? 2'd2 : 2'd1;
   wire [23:0]     dstr   = (dlen == 2'd3) ? {d_u, d_t, d_h} :
                            (dlen == 2'd2) ? {8'h00, d_u, d_t} : {16'h0000, d_u};
   wire [39:0]     d_tail = (40'({`ASR_CH_LF, `ASR_CH_CR}) << (5'(dlen) * 5'd8))
                            | 40'(dstr);
   // Query reply: decimal digits then a line end, led by a line end only when verbose, first byte lowest.
   wire [63:0]     q_buf  = verbose ? 64'({d_tail, `ASR_CH_LF, `ASR_CH_CR})
                                    : 64'(d_tail);
   wire [3:0]      q_len  = 4'(dlen) + (verbose ? 4'd4 : 4'd2);
   wire [63:0]     r_buf  = verbose ? 64'({`ASR_CH_LF, `ASR_CH_CR, `ASR_CH_K, `ASR_CH_O,
                                           `ASR_CH_LF, `ASR_CH_CR})
                                    : 64'({`ASR_CH_CR, `ASR_CH_0});
   wire [3:0]      r_len  = verbose ? 4'd6 : 4'd2;

   assign sif.rd_idx = pointer;

   // ****************************************************************
   // Parser next state
   // ****************************************************************
   always_comb begin
      next_state     = state;
      next_kind      = kind;
      next_pointer   = pointer;
      next_arg       = arg;
      next_num       = num;
      next_num_seen  = num_seen;
      next_val       = val;
      next_emit_buf  = emit_buf;
      next_emit_len  = emit_len;
      next_emit_pos  = emit_pos;
      next_emit_last = emit_last;
      next_tx_data   = tx_data_o;
      next_tx_valid  = tx_valid_o;
      sif.wr_en      = 1'b0;
      sif.wr_idx     = pointer;
      sif.wr_data    = 8'h00;
      sif.wr_mask    = 8'hff;
      case (state)
         ST_IDLE: begin
            if (rx_fire && ch == `ASR_CH_A) begin
               next_state = ST_GOT_A;
            end
         end
         ST_GOT_A: begin
            if (rx_fire) begin
               next_state = (ch == `ASR_CH_T) ? ST_CMD : ST_IDLE;
            end
         end
         ST_CMD: begin
            if (rx_fire) begin
               next_arg      = 4'h0;
               next_num      = 7'h00;
               next_num_seen = 1'b0;
               next_val      = 10'h000;
               if (is_cr) begin
                  // Q and V settings already stored govern this result.
                  next_emit_buf  = r_buf;
                  next_emit_len  = r_len;
                  next_emit_pos  = 4'h0;
                  next_emit_last = 1'b1;
                  next_state     = quiet ? ST_IDLE : ST_EMIT;
               end else if (ch == `ASR_CH_Q) begin
                  next_kind  = CK_QUIET;
                  next_state = ST_ARG;
               end else if (ch == `ASR_CH_V) begin
                  next_kind  = CK_VERBOSE;
                  next_state = ST_ARG;
               end else if (ch == `ASR_CH_S) begin
                  next_state = ST_SNUM;
               end else if (rx_data_i == `ASR_CH_EQ) begin
                  next_state = ST_SVAL;
               end else if (rx_data_i == `ASR_CH_QM) begin
                  // Any write from the same line has already landed.
                  next_emit_buf  = q_buf;
                  next_emit_len  = q_len;
                  next_emit_pos  = 4'h0;
                  next_emit_last = 1'b0;
                  next_state     = ST_EMIT;
               end else if (rx_data_i != `ASR_CH_SP && !is_digit) begin
                  next_kind  = CK_OTHER;
                  next_state = ST_ARG;
               end
            end
         end
         ST_ARG: begin
            if (rx_fire) begin
               next_arg = digit;
            end else if (hold) begin
               sif.wr_en   = (kind != CK_OTHER) && (arg <= 4'h1);
               sif.wr_idx  = IDX_W'(`ASR_IDX_OPT);
               sif.wr_mask = (kind == CK_QUIET) ? 8'(1 << `ASR_QUIET_BIT)
                                                : 8'(1 << `ASR_VERBOSE_BIT);
               sif.wr_data = {8{arg[0]}};
               next_state  = ST_CMD;
            end
         end
         ST_SNUM: begin
            if (rx_fire) begin
               // Any digit after a value of 10 or more passes the limit, so saturate before it overflows.
               next_num      = (num >= 7'd10) ? `ASR_NUM_MAX : 7'(num * 7'd10 + 7'(digit));
               next_num_seen = 1'b1;
            end else if (hold) begin
               if (num_ok) begin
                  next_pointer = IDX_W'(num);
               end
               next_state = ST_CMD;
            end
         end
         ST_SVAL: begin
            if (rx_fire) begin
               next_val = (val >= 10'd100) ? `ASR_VAL_MAX : 10'(val * 10'd10 + 10'(digit));
            end else if (hold) begin
               sif.wr_en   = 1'b1;
               sif.wr_idx  = pointer;
               sif.wr_data = val[7:0];
               next_state  = ST_CMD;
            end
         end
         ST_EMIT: begin
            if (!tx_valid_o || tx_ready_i) begin
               if (emit_pos < emit_len) begin
                  next_tx_data  = emit_buf[emit_pos*8 +: 8];
                  next_tx_valid = 1'b1;
                  next_emit_pos = emit_pos + 4'h1;
               end else begin
                  next_tx_valid = 1'b0;
                  next_state    = emit_last ? ST_IDLE : ST_CMD;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state     <= ST_IDLE;
         kind      <= CK_OTHER;
         pointer   <= '0;
         arg       <= 4'h0;
         num       <= 7'h00;
         num_seen  <= 1'b0;
         val       <= 10'h000;
      end else begin
         state     <= next_state;
         kind      <= next_kind;
         pointer   <= next_pointer;
         arg       <= next_arg;
         num       <= next_num;
         num_seen  <= next_num_seen;
         val       <= next_val;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         emit_buf   <= 64'h0;
         emit_len   <= 4'h0;
         emit_pos   <= 4'h0;
         emit_last  <= 1'b0;
         tx_data_o  <= 8'h00;
         tx_valid_o <= 1'b0;
      end else begin
         emit_buf   <= next_emit_buf;
         emit_len   <= next_emit_len;
         emit_pos   <= next_emit_pos;
         emit_last  <= next_emit_last;
         tx_data_o  <= next_tx_data;
         tx_valid_o <= next_tx_valid;
      end
   end

   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   logic       wr_pend;
   logic       rd_pend;
   logic [7:0] dp_addr;

   // Reads take one wait state so that a write just before is visible.
   wire        ahb_take  = hsel_i && htrans_i[1] && hready_i;
   wire        dp_wr     = wr_pend;
   wire        wr_ctrl   = dp_wr && (dp_addr == `ASR_OFS_CTRL);
   wire        wr_pk_idx = dp_wr && (dp_addr == `ASR_OFS_PEEK_IDX);
   wire [31:0] status    = {20'h0, enable, (state == ST_EMIT), verbose, !quiet,
                            8'(pointer)};
   wire [31:0] peek_data = {sif.pk_prof1, sif.pk_prof0, sif.pk_eff, sif.pk_raw};
   wire [31:0] rd_mux    = (dp_addr == `ASR_OFS_CTRL)      ? {31'h0, enable} :
                           (dp_addr == `ASR_OFS_STATUS)    ? status :
                           (dp_addr == `ASR_OFS_PEEK_IDX)  ? 32'(pk_idx) :
                           (dp_addr == `ASR_OFS_PEEK_DATA) ? peek_data : 32'h0;

   assign hreadyout_o   = !rd_pend;
   assign hresp_o       = 1'b0;
   assign sif.fact_load = wr_ctrl && hwdata_i[`ASR_CTRL_FACT_BIT];
   assign sif.pk_idx    = pk_idx;

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         wr_pend <= ahb_take && hwrite_i;
         rd_pend <= ahb_take && !hwrite_i;
         if (ahb_take) begin
            dp_addr <= haddr_i[7:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         enable   <= `ASR_CTRL_RESET;
         pk_idx   <= '0;
         hrdata_o <= 32'h0;
      end else begin
         if (wr_ctrl) begin
            enable <= hwdata_i[`ASR_CTRL_EN_BIT];
         end
         if (wr_pk_idx) begin
            pk_idx <= hwdata_i[IDX_W-1:0];
         end
         if (rd_pend) begin
            hrdata_o <= rd_mux;
         end
      end
   end

endmodule // asr_top
